// [hw/line_loopback_error_monitor.sv]
// loopback control, bit error counter and block error counters of one line port
// assumes an apb master on clk, slot data and superframe events from the framer
//
// The register addresses and register access over APB were decided locally.
module line_loopback_error_monitor #(
  parameter logic [1:0] PORT_ID = 2'h0
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  act_state,
  output logic             act_inhibit,
  input  wire logic        slot_valid,
  input  wire logic [1:0]  slot_chan,
  input  wire logic [7:0]  sys_in_data,
  input  wire logic [7:0]  line_in_data,
  output logic             out_valid,
  output logic      [7:0]  sys_out_data,
  output logic      [7:0]  line_out_data,
  input  wire logic        sf_done,
  input  wire logic [11:0] sf_crc_calc,
  input  wire logic [11:0] sf_crc_rx,
  input  wire logic        rx_far_end_block_error_bit,
  output logic             tx_far_end_block_error_bit,
  output logic             err_msg_valid,
  output logic      [1:0]  err_msg_code,
  input  wire logic        line_rmsg_valid,
  input  wire logic [7:0]  line_rmsg_code,
  output logic             line_rmsg_tx_valid,
  output logic      [7:0]  line_rmsg_tx_code,
  output logic             host_rmsg_valid,
  output logic      [7:0]  host_rmsg_code,
  input  wire logic        host_rmsg_in_valid,
  input  wire logic [7:0]  host_rmsg_in_code,
  input  wire logic        lmsg_valid,
  input  wire logic [7:0]  lmsg_code,
  output logic             lmsg_ans_valid,
  output logic      [7:0]  lmsg_ans_data
);
  typedef struct packed {
    logic [1:0]                   loop_sel;
    logic                         loop_dir;
    logic                         pass;
    logic                         framer;
    logic                         eoc_transp;
    logic [1:0]                   ber_sel;
    logic [1:0]                   lps;
    logic                         rem_b1;
    logic                         rem_b2;
    logic [line_mon_pkg::CRC_W-1:0] prev_crc;
    logic                         crc_primed;
    logic                         tx_far_end_block_error;
    logic                         tx_rm_v;
    logic [7:0]                   tx_rm_c;
    logic                         host_rm_v;
    logic [7:0]                   host_rm_c;
    line_mon_pkg::ans_phase_e     ans;
    logic [7:0]                   ans_cnt;
    logic                         ans_v;
    logic [7:0]                   ans_d;
    logic                         ov;
    logic [7:0]                   sys_o;
    logic [7:0]                   line_o;
    logic                         err_v;
    logic [1:0]                   err_c;
    logic                         inhibit;
    logic [31:0]                  rdata;
    logic                         serr;
  } st_s;

  st_s s;
  st_s next_s;

  logic [line_mon_pkg::BIT_ERROR_COUNT_W-1:0] bit_error_count;
  logic [line_mon_pkg::BLK_W-1:0]  near_end_block_error;
  logic [line_mon_pkg::BLK_W-1:0]  far_end_block_error;
  logic [line_mon_pkg::INC_W-1:0]  ber_inc;
  logic                            bit_error_count_clr;
  logic                            near_clr;
  logic                            far_clr;
  logic                            near_err;
  logic                            far_err;
  logic                            cnt_en;
  logic                            setup;
  logic                            access;
  logic                            sel_ok;
  logic                            loc_hit;
  logic                            local_sys;
  logic                            local_line;
  logic                            rem_hit;
  logic                            ber_hit;

  function automatic logic [line_mon_pkg::INC_W-1:0] ones(input logic [7:0] d);
    logic [line_mon_pkg::INC_W-1:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, d[i]};
    end
    return n;
  endfunction

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign sel_ok = (s.lps == PORT_ID);
  assign cnt_en = (act_state == line_mon_pkg::ACT_LINE_ACT)
               || (act_state == line_mon_pkg::ACT_PEND_LOOPBACK_PASSTHROUGH_SEL)
               || (act_state == line_mon_pkg::ACT_LOOPBACK_PASSTHROUGH_SEL)
               || (act_state == line_mon_pkg::ACT_ST_DEACT);

  // computed checksum is checked against the next superframe's field
  assign near_err = sf_done && s.crc_primed && (s.prev_crc != sf_crc_rx);
  assign far_err  = sf_done && !rx_far_end_block_error_bit;

  assign loc_hit = (s.loop_sel == line_mon_pkg::SEL_ALL)
                || (s.loop_sel == line_mon_pkg::SEL_B1 && slot_chan == line_mon_pkg::CH_B1)
                || (s.loop_sel == line_mon_pkg::SEL_B2 && slot_chan == line_mon_pkg::CH_B2);
  assign local_sys  = loc_hit && !s.loop_dir;
  assign local_line = loc_hit && s.loop_dir;
  assign rem_hit = (s.rem_b1 && slot_chan == line_mon_pkg::CH_B1)
                || (s.rem_b2 && slot_chan == line_mon_pkg::CH_B2);
  assign ber_hit = (s.ber_sel == line_mon_pkg::SEL_B1 && slot_chan == line_mon_pkg::CH_B1)
                || (s.ber_sel == line_mon_pkg::SEL_B2 && slot_chan == line_mon_pkg::CH_B2)
                || (s.ber_sel == line_mon_pkg::SEL_ALL && slot_chan != 2'h3);
  assign ber_inc = (slot_valid && ber_hit) ? ones(line_in_data) : '0;

  assign bit_error_count_clr = setup && !pwrite && paddr == line_mon_pkg::ADDR_BIT_ERROR_COUNT && sel_ok;
  assign near_clr = lmsg_valid && s.ans == line_mon_pkg::ANS_IDLE
                 && lmsg_code == line_mon_pkg::READ_NEAR_ERRORS_CMD;
  assign far_clr  = lmsg_valid && s.ans == line_mon_pkg::ANS_IDLE
                 && lmsg_code == line_mon_pkg::READ_FAR_ERRORS_CMD;

  always_comb begin
    next_s = s;
    next_s.tx_rm_v = 1'b0;
    next_s.host_rm_v = 1'b0;
    next_s.ans_v = 1'b0;
    next_s.ov = 1'b0;
    next_s.err_v = 1'b0;
    // read data is latched in the setup cycle, read side effects happen there too
    if (setup && !pwrite) begin
      next_s.serr = 1'b0;
      next_s.rdata = '0;
      unique case (paddr)
        line_mon_pkg::ADDR_LOOP: begin
          next_s.rdata[line_mon_pkg::LOOP_SEL_LSB +: 2] = s.loop_sel;
          next_s.rdata[line_mon_pkg::LOOP_DIR_BIT] = s.loop_dir;
          next_s.rdata[line_mon_pkg::LOOP_PASS_BIT] = s.pass;
          next_s.rdata[line_mon_pkg::LOOP_FRAMER_BIT] = s.framer;
          next_s.rdata[line_mon_pkg::LOOP_EOCTR_BIT] = s.eoc_transp;
        end
        line_mon_pkg::ADDR_TEST: next_s.rdata[1:0] = sel_ok ? s.ber_sel : 2'h0;
        line_mon_pkg::ADDR_BIT_ERROR_COUNT: next_s.rdata[15:0] = sel_ok ? bit_error_count : 16'h0000;
        line_mon_pkg::ADDR_LPS:  next_s.rdata[1:0] = s.lps;
        line_mon_pkg::ADDR_STAT: begin
          next_s.rdata[7:0] = near_end_block_error;
          next_s.rdata[line_mon_pkg::STAT_FAR_LSB +: 8] = far_end_block_error;
          next_s.rdata[line_mon_pkg::STAT_REM1_BIT] = s.rem_b1;
          next_s.rdata[line_mon_pkg::STAT_REM2_BIT] = s.rem_b2;
          next_s.rdata[line_mon_pkg::STAT_INH_BIT] = s.inhibit;
          next_s.rdata[line_mon_pkg::STAT_FAR_END_BLOCK_ERROR_BIT] = s.tx_far_end_block_error;
        end
        default: next_s.serr = 1'b1;
      endcase
    end else if (setup) begin
      next_s.rdata = '0;
      next_s.serr = !(paddr == line_mon_pkg::ADDR_LOOP || paddr == line_mon_pkg::ADDR_TEST
                   || paddr == line_mon_pkg::ADDR_BIT_ERROR_COUNT || paddr == line_mon_pkg::ADDR_LPS
                   || paddr == line_mon_pkg::ADDR_STAT);
    end
    if (access && pwrite) begin
      if (paddr == line_mon_pkg::ADDR_LOOP) begin
        next_s.loop_sel = pwdata[line_mon_pkg::LOOP_SEL_LSB +: 2];
        next_s.loop_dir = pwdata[line_mon_pkg::LOOP_DIR_BIT];
        next_s.pass = pwdata[line_mon_pkg::LOOP_PASS_BIT];
        next_s.framer = pwdata[line_mon_pkg::LOOP_FRAMER_BIT];
        next_s.eoc_transp = pwdata[line_mon_pkg::LOOP_EOCTR_BIT];
        // remembered until the framer loop is opened again
        if (!pwdata[line_mon_pkg::LOOP_FRAMER_BIT]) begin
          next_s.inhibit = 1'b0;
        end else if (act_state == line_mon_pkg::ACT_DEACT) begin
          next_s.inhibit = 1'b1;
        end
      end
      if (paddr == line_mon_pkg::ADDR_TEST && sel_ok) begin
        next_s.ber_sel = pwdata[1:0];
      end
      if (paddr == line_mon_pkg::ADDR_LPS) begin
        next_s.lps = pwdata[1:0];
      end
    end
    // remote maintenance messages from the line
    if (line_rmsg_valid && s.eoc_transp) begin
      next_s.host_rm_v = 1'b1;
      next_s.host_rm_c = line_rmsg_code;
    end else if (line_rmsg_valid) begin
      unique case (line_rmsg_code)
        line_mon_pkg::LOOP_FIRST_BEARER_CMD: begin
          next_s.rem_b1 = 1'b1;
          next_s.tx_rm_v = 1'b1;
          next_s.tx_rm_c = line_rmsg_code;
        end
        line_mon_pkg::LOOP_SECOND_BEARER_CMD: begin
          next_s.rem_b2 = 1'b1;
          next_s.tx_rm_v = 1'b1;
          next_s.tx_rm_c = line_rmsg_code;
        end
        line_mon_pkg::RETURN_TO_NORMAL_CMD: begin
          next_s.rem_b1 = 1'b0;
          next_s.rem_b2 = 1'b0;
          next_s.tx_rm_v = 1'b1;
          next_s.tx_rm_c = line_rmsg_code;
        end
        default: next_s.tx_rm_v = 1'b0;
      endcase
    end
    // host supplies the acknowledge itself in transparent mode
    if (host_rmsg_in_valid && s.eoc_transp) begin
      next_s.tx_rm_v = 1'b1;
      next_s.tx_rm_c = host_rmsg_in_code;
    end
    // local maintenance commands
    if (lmsg_valid) begin
      if (lmsg_code == line_mon_pkg::LOCAL_FIRST_LOOP_CMD) begin
        next_s.rem_b1 = 1'b1;
      end else if (lmsg_code == line_mon_pkg::LOCAL_SECOND_LOOP_CMD) begin
        next_s.rem_b2 = 1'b1;
      end else if (lmsg_code == line_mon_pkg::LOCAL_NORMAL_CMD) begin
        next_s.rem_b1 = 1'b0;
        next_s.rem_b2 = 1'b0;
      end
    end
    // two byte answer: header, then the count taken before the clear
    unique case (s.ans)
      line_mon_pkg::ANS_IDLE: begin
        if (near_clr || far_clr) begin
          next_s.ans = line_mon_pkg::ANS_VAL;
          next_s.ans_cnt = near_clr ? near_end_block_error : far_end_block_error;
          next_s.ans_v = 1'b1;
          next_s.ans_d = line_mon_pkg::ANSWER_HEADER;
        end
      end
      line_mon_pkg::ANS_VAL: begin
        next_s.ans = line_mon_pkg::ANS_IDLE;
        next_s.ans_v = 1'b1;
        next_s.ans_d = s.ans_cnt;
      end
    endcase
    // superframe events
    if (!cnt_en) begin
      next_s.crc_primed = 1'b0;
    end else if (sf_done) begin
      next_s.prev_crc = sf_crc_calc;
      next_s.crc_primed = 1'b1;
    end
    if (sf_done) begin
      next_s.tx_far_end_block_error = !near_err;
      next_s.err_v = near_err || far_err;
      next_s.err_c = (near_err && far_err) ? line_mon_pkg::ERR_BOTH
                   : near_err ? line_mon_pkg::ERR_NEAR : line_mon_pkg::ERR_FAR;
    end
    // slot data path
    if (slot_valid) begin
      next_s.ov = 1'b1;
      next_s.sys_o = line_in_data;
      next_s.line_o = sys_in_data;
      if (s.framer) begin
        next_s.sys_o = sys_in_data;
        next_s.line_o = sys_in_data;
      end else if (local_sys) begin
        next_s.sys_o = sys_in_data;
        next_s.line_o = s.pass ? sys_in_data : line_mon_pkg::IDLE_BYTE;
      end else if (local_line) begin
        next_s.line_o = line_in_data;
        next_s.sys_o = s.pass ? line_in_data : line_mon_pkg::IDLE_BYTE;
      end else if (rem_hit) begin
        next_s.line_o = line_in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.loop_sel <= line_mon_pkg::LOOP_SEL_RST;
      s.ber_sel <= line_mon_pkg::BER_SEL_RST;
      s.lps <= line_mon_pkg::LPS_RST;
      s.tx_far_end_block_error <= 1'b1;
      s.ans <= line_mon_pkg::ANS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  sat_counter #(.W(line_mon_pkg::BIT_ERROR_COUNT_W), .IW(line_mon_pkg::INC_W)) u_bit_error_count (
    .clk       (clk),
    .nrst      (nrst),
    .hold_zero (1'b0),
    .clr       (bit_error_count_clr),
    .inc       (ber_inc),
    .count     (bit_error_count)
  );

  sat_counter #(.W(line_mon_pkg::BLK_W), .IW(1)) u_near (
    .clk       (clk),
    .nrst      (nrst),
    .hold_zero (!cnt_en),
    .clr       (near_clr),
    .inc       (near_err),
    .count     (near_end_block_error)
  );

  sat_counter #(.W(line_mon_pkg::BLK_W), .IW(1)) u_far (
    .clk       (clk),
    .nrst      (nrst),
    .hold_zero (!cnt_en),
    .clr       (far_clr),
    .inc       (far_err),
    .count     (far_end_block_error)
  );

  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = s.serr;
  assign act_inhibit = s.inhibit;
  assign out_valid = s.ov;
  assign sys_out_data = s.sys_o;
  assign line_out_data = s.line_o;
  assign tx_far_end_block_error_bit = s.tx_far_end_block_error;
  assign err_msg_valid = s.err_v;
  assign err_msg_code = s.err_c;
  assign line_rmsg_tx_valid = s.tx_rm_v;
  assign line_rmsg_tx_code = s.tx_rm_c;
  assign host_rmsg_valid = s.host_rm_v;
  assign host_rmsg_code = s.host_rm_c;
  assign lmsg_ans_valid = s.ans_v;
  assign lmsg_ans_data = s.ans_d;

  AST_ECHO_LOOP: assert property (@(posedge clk) disable iff (!nrst)
    (line_rmsg_valid && !s.eoc_transp && !host_rmsg_in_valid
     && line_rmsg_code == line_mon_pkg::LOOP_FIRST_BEARER_CMD)
    |=> line_rmsg_tx_valid && line_rmsg_tx_code == 8'h51 && s.rem_b1)
    else $error("first bearer loop not closed and echoed");
  AST_LOCAL_LOOP: assert property (@(posedge clk) disable iff (!nrst)
    (lmsg_valid && lmsg_code == 8'hF2) |=> s.rem_b2)
    else $error("local second loop command ignored");
  AST_RETURN_NORMAL: assert property (@(posedge clk) disable iff (!nrst)
    (line_rmsg_valid && !s.eoc_transp && line_rmsg_code == 8'hFF && !lmsg_valid)
    |=> !s.rem_b1 && !s.rem_b2)
    else $error("return to normal left a loop closed");
  AST_IDLE_FILL: assert property (@(posedge clk) disable iff (!nrst)
    (slot_valid && !s.framer && local_line && !s.pass)
    |=> out_valid && sys_out_data == 8'hFF)
    else $error("non transparent loop forwarded data");
  AST_FRAMER_TRANSP: assert property (@(posedge clk) disable iff (!nrst)
    (slot_valid && s.framer) |=> line_out_data == $past(sys_in_data)
     && sys_out_data == $past(sys_in_data))
    else $error("framer loop not transparent");
  AST_INHIBIT: assert property (@(posedge clk) disable iff (!nrst)
    (access && pwrite && paddr == 8'h00 && pwdata[4] && act_state == 3'h0)
    |=> act_inhibit)
    else $error("activation not inhibited");
  AST_BER_STOP: assert property (@(posedge clk) disable iff (!nrst)
    (s.ber_sel == 2'h0 && !bit_error_count_clr) |=> $stable(bit_error_count))
    else $error("bit error counter moved while stopped");
  AST_BIT_ERROR_COUNT_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    (bit_error_count_clr && ber_inc == '0) |=> bit_error_count == 16'h0000)
    else $error("bit error counter not cleared by read");
  AST_BIT_ERROR_COUNT_SAT: assert property (@(posedge clk) disable iff (!nrst)
    (bit_error_count == 16'hFFFF && !bit_error_count_clr) |=> bit_error_count == 16'hFFFF)
    else $error("bit error counter wrapped");
  AST_NEAR_SAT: assert property (@(posedge clk) disable iff (!nrst)
    (near_end_block_error == 8'hFF && !near_clr && cnt_en) |=> near_end_block_error == 8'hFF || !$past(cnt_en))
    else $error("near end counter wrapped");
  AST_NEAR_ANSWER: assert property (@(posedge clk) disable iff (!nrst)
    near_clr |=> lmsg_ans_valid && lmsg_ans_data == 8'h80
     ##1 lmsg_ans_valid && lmsg_ans_data == $past(near_end_block_error, 2))
    else $error("near end answer wrong");
  AST_FAR_END_BLOCK_ERROR_TX: assert property (@(posedge clk) disable iff (!nrst)
    sf_done |=> tx_far_end_block_error_bit == !$past(near_err))
    else $error("far end bit not driven from near error");
  AST_HOLD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    !cnt_en |=> near_end_block_error == 8'h00 && far_end_block_error == 8'h00)
    else $error("block counters not held at zero");
endmodule

// [pkg/line_mon_pkg.sv]
// constants shared by the line port maintenance and test logic
// assumes one 100 MHz clock and an apb slave with 8 address bits
package line_mon_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_LOOP = 8'h00;
  localparam logic [7:0] ADDR_TEST = 8'h04;
  localparam logic [7:0] ADDR_BIT_ERROR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_LPS  = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // loop register fields
  localparam int LOOP_SEL_LSB    = 0;
  localparam int LOOP_DIR_BIT    = 2;
  localparam int LOOP_PASS_BIT   = 3;
  localparam int LOOP_FRAMER_BIT = 4;
  localparam int LOOP_EOCTR_BIT  = 5;
  // status register fields
  localparam int STAT_FAR_LSB  = 8;
  localparam int STAT_REM1_BIT = 16;
  localparam int STAT_REM2_BIT = 17;
  localparam int STAT_INH_BIT  = 18;
  localparam int STAT_FAR_END_BLOCK_ERROR_BIT = 19;
  // reset values
  localparam logic [1:0] LOOP_SEL_RST = 2'h0;
  localparam logic [1:0] BER_SEL_RST  = 2'h0;
  localparam logic [1:0] LPS_RST      = 2'h0;
  // widths
  localparam int BIT_ERROR_COUNT_W = 16;
  localparam int BLK_W  = 8;
  localparam int CRC_W  = 12;
  localparam int INC_W  = 4;
  // loop and bit error channel selections
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_B1  = 2'h1;
  localparam logic [1:0] SEL_B2  = 2'h2;
  localparam logic [1:0] SEL_ALL = 2'h3;
  // slot channel codes
  localparam logic [1:0] CH_B1 = 2'h0;
  localparam logic [1:0] CH_B2 = 2'h1;
  localparam logic [1:0] CH_D  = 2'h2;
  // activation state codes seen from the activation logic
  localparam logic [2:0] ACT_DEACT      = 3'h0;
  localparam logic [2:0] ACT_LINE_ACT   = 3'h1;
  localparam logic [2:0] ACT_PEND_LOOPBACK_PASSTHROUGH_SEL = 3'h2;
  localparam logic [2:0] ACT_LOOPBACK_PASSTHROUGH_SEL      = 3'h3;
  localparam logic [2:0] ACT_ST_DEACT   = 3'h4;
  // maintenance codes
  localparam logic [7:0] LOOP_FIRST_BEARER_CMD  = 8'h51;
  localparam logic [7:0] LOOP_SECOND_BEARER_CMD = 8'h52;
  localparam logic [7:0] RETURN_TO_NORMAL_CMD   = 8'hFF;
  localparam logic [7:0] LOCAL_FIRST_LOOP_CMD   = 8'hF4;
  localparam logic [7:0] LOCAL_SECOND_LOOP_CMD  = 8'hF2;
  localparam logic [7:0] LOCAL_NORMAL_CMD       = 8'hFF;
  localparam logic [7:0] READ_NEAR_ERRORS_CMD   = 8'hFB;
  localparam logic [7:0] READ_FAR_ERRORS_CMD    = 8'hFA;
  localparam logic [7:0] ANSWER_HEADER          = 8'h80;
  localparam logic [7:0] IDLE_BYTE              = 8'hFF;
  // error report codes
  localparam logic [1:0] ERR_NEAR = 2'h1;
  localparam logic [1:0] ERR_FAR  = 2'h2;
  localparam logic [1:0] ERR_BOTH = 2'h3;
  typedef enum logic [0:0] {ANS_IDLE, ANS_VAL} ans_phase_e;
endpackage

// [hw/sat_counter.sv]
// saturating counter with clear and hold at zero
// assumes clear and increment come from the same clock domain
module sat_counter #(
  parameter int W  = 8,
  parameter int IW = 1
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          hold_zero,
  input  wire logic          clr,
  input  wire logic [IW-1:0] inc,
  output logic      [W-1:0]  count
);
  typedef struct packed {
    logic [W-1:0] count;
  } cnt_s;

  cnt_s s;
  cnt_s next_s;

  always_comb begin
    logic [W:0] sum;
    sum = '0;
    next_s = s;
    // increment lands on the cleared value, so no event is lost
    sum = (clr ? '0 : {1'b0, s.count}) + {{(W + 1 - IW){1'b0}}, inc};
    if (hold_zero) begin
      next_s.count = '0;
    end else if (sum[W]) begin
      next_s.count = '1;
    end else begin
      next_s.count = sum[W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;
endmodule

// [bench/host_ctrl_model.sv]
// host controller model beside the maintenance side of one line port
// assumes forwarded remote messages arrive as one-cycle pulses on clk
module host_ctrl_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       rmsg_valid,
  input  wire logic [7:0] rmsg_code,
  output logic            echo_valid,
  output logic      [7:0] echo_code
);
  timeunit 1ns;
  timeprecision 100ps;
  // echo each forwarded message; code line scrambled between messages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      echo_valid <= 1'b0;
      echo_code  <= 8'h00;
    end else begin
      echo_valid <= rmsg_valid;
      echo_code  <= rmsg_valid ? rmsg_code : ~echo_code;
    end
  end
endmodule

// [bench/line_loopback_error_monitor_bench.sv]
// self-checking bench for the line port loopback and error monitor
// assumes host_ctrl_model echoes forwarded remote messages
module line_loopback_error_monitor_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, psel, penable, pwrite, slot_valid, sf_done, rx_far_end_block_error_bit, er;
  logic line_rmsg_valid, lmsg_valid, pready, pslverr, act_inhibit, out_valid;
  logic tx_far_end_block_error_bit, err_msg_valid, line_rmsg_tx_valid, host_rmsg_valid;
  logic host_rmsg_in_valid, lmsg_ans_valid;
  logic [1:0] slot_chan, err_msg_code;
  logic [2:0] act_state;
  logic [7:0] paddr, sys_in_data, line_in_data, sys_out_data, line_out_data, lmsg_code;
  logic [7:0] line_rmsg_code, line_rmsg_tx_code, host_rmsg_code, host_rmsg_in_code;
  logic [7:0] lmsg_ans_data;
  logic [11:0] sf_crc_calc, sf_crc_rx;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, n_checks;
  line_loopback_error_monitor dut (.*);
  host_ctrl_model host (.clk(clk), .nrst(nrst), .rmsg_valid(host_rmsg_valid),
    .rmsg_code(host_rmsg_code), .echo_valid(host_rmsg_in_valid),
    .echo_code(host_rmsg_in_code));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk);
    {slot_valid, sf_done, line_rmsg_valid, lmsg_valid} <= 4'h0;
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic slot(input logic [1:0] c, input logic [7:0] s, l);
    @(posedge clk);
    {slot_valid, slot_chan, sys_in_data, line_in_data} <= {1'b1, c, s, l};
    step;
  endtask
  task automatic sf(input logic [11:0] c, r, input logic f);
    @(posedge clk);
    {sf_done, sf_crc_calc, sf_crc_rx, rx_far_end_block_error_bit} <= {1'b1, c, r, f};
    step;
  endtask
  task automatic rmsg(input logic [7:0] c);
    @(posedge clk);
    {line_rmsg_valid, line_rmsg_code} <= {1'b1, c};
    step;
  endtask
  task automatic lcmd(input logic [7:0] c);
    @(posedge clk);
    {lmsg_valid, lmsg_code} <= {1'b1, c};
    step;
  endtask
  task automatic rdcnt(input logic [7:0] c, exp);
    lcmd(c);
    chk({lmsg_ans_valid, lmsg_ans_data}, 9'h180);
    @(posedge clk);
    #1;
    chk({lmsg_ans_valid, lmsg_ans_data}, {1'b1, exp});
  endtask
  task automatic t_ber;
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    repeat (3) slot(2'h0, 8'h00, 8'h0F);
    slot(2'h1, 8'h00, 8'hFF);
    apb(1'b1, 8'h04, 32'h0);
    slot(2'h0, 8'h00, 8'hFF);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'hC);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h04, 32'h3);
    slot(2'h2, 8'h00, 8'h81);
    slot(2'h3, 8'h00, 8'hFF);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h04, 32'h1);
    repeat (8192) slot(2'h0, 8'h00, 8'hFF);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'hFFFF);
    apb(1'b1, 8'h04, 32'h0);
    $display("bit error test done");
  endtask
  task automatic t_blk;
    chk(tx_far_end_block_error_bit, 1'b1);
    sf(12'h111, 12'h000, 1'b1);
    sf(12'h222, 12'h111, 1'b1);
    chk(err_msg_valid, 1'b0);
    sf(12'h333, 12'h000, 1'b1);
    chk({tx_far_end_block_error_bit, err_msg_valid, err_msg_code}, 4'h5);
    sf(12'h444, 12'h333, 1'b1);
    chk(tx_far_end_block_error_bit, 1'b1);
    sf(12'h555, 12'h444, 1'b0);
    chk({err_msg_valid, err_msg_code}, 3'h6);
    sf(12'h001, 12'h000, 1'b0);
    chk({err_msg_valid, err_msg_code}, 3'h7);
    rdcnt(8'hFA, 8'h02);
    repeat (300) sf(12'h001, 12'hFFF, 1'b1);
    rdcnt(8'hFB, 8'hFF);
    rdcnt(8'hFB, 8'h00);
    sf(12'h001, 12'h001, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:8], 8'h01);
    @(posedge clk);
    act_state <= 3'h0;
    sf(12'h001, 12'hFFF, 1'b0);
    @(posedge clk);
    act_state <= 3'h1;
    rdcnt(8'hFA, 8'h00);
    $display("block error test done");
  endtask
  task automatic t_rem;
    logic [7:0] cs [3] = '{8'h51, 8'h52, 8'hFF};
    logic [1:0] st [3] = '{2'h1, 2'h3, 2'h0};
    for (int i = 0; i < 3; i++) begin
      rmsg(cs[i]);
      chk({line_rmsg_tx_valid, line_rmsg_tx_code}, {1'b1, cs[i]});
      apb(1'b0, 8'h10, 32'h0);
      chk(rd[17:16], st[i]);
    end
    apb(1'b1, 8'h00, 32'h20);
    rmsg(8'h52);
    chk({host_rmsg_valid, host_rmsg_code, line_rmsg_tx_valid}, 10'h2A4);
    repeat (2) @(posedge clk);
    #1;
    chk({line_rmsg_tx_valid, line_rmsg_tx_code}, 9'h152);
    lcmd(8'hF4);
    lcmd(8'hF2);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[17:16], 2'h3);
    lcmd(8'hFF);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[17:16], 2'h0);
    $display("remote loop test done");
  endtask
  task automatic t_loop;
    apb(1'b1, 8'h00, 32'h01);
    slot(2'h0, 8'hA5, 8'h3C);
    chk({out_valid, sys_out_data, line_out_data}, 17'h1A5FF);
    apb(1'b1, 8'h00, 32'h0D);
    slot(2'h0, 8'hA5, 8'h3C);
    chk({out_valid, sys_out_data, line_out_data}, 17'h13C3C);
    apb(1'b1, 8'h00, 32'h05);
    slot(2'h0, 8'hA5, 8'h3C);
    chk({out_valid, sys_out_data, line_out_data}, 17'h1FF3C);
    @(posedge clk);
    act_state <= 3'h0;
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h10, 32'h0);
    chk({act_inhibit, rd[18]}, 2'h3);
    slot(2'h0, 8'h5A, 8'h00);
    chk({out_valid, sys_out_data, line_out_data}, 17'h15A5A);
    $display("local loop test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {slot_valid, slot_chan, sys_in_data, line_in_data} <= '0;
    {sf_done, sf_crc_calc, sf_crc_rx, rx_far_end_block_error_bit} <= {25'h0, 1'b1};
    {line_rmsg_valid, line_rmsg_code, lmsg_valid, lmsg_code} <= '0;
    act_state <= 3'h1;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_ber;
    t_blk;
    t_rem;
    t_loop;
    report_and_stop;
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    report_and_stop;
  end
endmodule
